/* core/fri_target.sv */
// Memory target end of the two-wire link, clocked by the link clock
//
// Contract
// - Current read starts at latched address
// - Controller sets address LSB 1 to read
// - Shift out current byte after address ack
// - Address counter increments after every sent byte
// - Controller ack fetches next sequential byte
// - Preferred end: nack ninth, STOP tenth
// - Alternative end: nack ninth, START tenth
// - STOP in ninth clock ends output
// - START in ninth clock abandons read
// - Controller must use a permitted end
// - Counter wraps 1FFFh to 0000h
// - Write header with memory address loads latch
// - Repeated START abandons write, then read
// - Respond only to matching type and select
// - Two address bytes form 13-bit latch
// - Increment just before the acknowledge slot
// - All bytes travel MSB first
`timescale 1ns/1ps
`default_nettype none
module fri_target
  import fri_pkg::*;
(
  fri_link_if.dev link,
  input wire logic rst_n_in,
  input wire logic [DSEL_W-1:0] device_select_pins_in,
  output logic [ADDR_W-1:0] current_addr_out
);

  // ==================================================================
  // Declarations
  typedef enum logic [3:0] {
    T_IDLE,
    T_SLAVE,
    T_SLAVE_ACK,
    T_MHI,
    T_MHI_ACK,
    T_MLO,
    T_MLO_ACK,
    T_WDATA,
    T_WDATA_ACK,
    T_RDATA,
    T_RACK
  } fri_tstate_e;

  fri_tstate_e state_q;
  logic [BYTE_W-1:0] mem_q [0:(1<<ADDR_W)-1];
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_next;
  logic [ADDR_W-BYTE_W-1:0] hi_q;
  logic [2:0] cnt_q;
  logic [BYTE_W-1:0] rx_q;
  logic [BYTE_W-1:0] tx_q;
  logic [BYTE_W-1:0] byte_in;
  logic [BYTE_W-1:0] mem_rd;
  logic rw_q;
  logic oe_q;
  logic sda_o_q;
  logic sda_pos_q;
  logic start_tgl_q;
  logic stop_tgl_q;
  logic start_seen_q;
  logic stop_seen_q;
  logic cond_start;
  logic cond_stop;
  logic wr_fire;
  logic addr_match;
  logic [DSEL_W-1:0] dsel_meta_q;
  logic [DSEL_W-1:0] dsel_q;

  // ==================================================================
  // Bus conditions
  // Seen on SDA edges while SCL is high; the link protocol keeps the
  // toggle stable for a quarter SCL period, half the SCL high time, before the next SCL fall.
  always_ff @(negedge link.sda or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_tgl_q <= 1'b0;
    end else if (link.scl) begin
      start_tgl_q <= ~start_tgl_q;
    end
  end

  always_ff @(posedge link.sda or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stop_tgl_q <= 1'b0;
    end else if (link.scl) begin
      stop_tgl_q <= ~stop_tgl_q;
    end
  end

  assign cond_start = start_tgl_q != start_seen_q;
  assign cond_stop = stop_tgl_q != stop_seen_q;

  // ==================================================================
  // Input sampling
  // SDA is sampled on the rising link clock; it is synchronous to it
  // by protocol, so a synchroniser here would break the bit timing.
  always_ff @(posedge link.scl or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sda_pos_q <= 1'b1;
    end else begin
      sda_pos_q <= link.sda;
    end
  end

  // Static straps, still passed through two stages
  always_ff @(posedge link.scl or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dsel_meta_q <= '0;
      dsel_q <= '0;
    end else begin
      dsel_meta_q <= device_select_pins_in;
      dsel_q <= dsel_meta_q;
    end
  end

  // ==================================================================
  // Byte assembly and address arithmetic
  assign byte_in = {rx_q[BYTE_W-2:0], sda_pos_q};
  assign addr_match = (byte_in[7:4] == DEV_TYPE) && (byte_in[3:1] == dsel_q);
  assign addr_next = (addr_q == ADDR_TOP) ? ADDR_WRAP : addr_q + ADDR_W'(1);
  assign mem_rd = mem_q[addr_q];
  assign wr_fire = rst_n_in && (state_q == T_WDATA) && (cnt_q == BIT_LAST) &&
                   !cond_start && !cond_stop;

  // ==================================================================
  // Memory array
  always_ff @(negedge link.scl) begin
    if (wr_fire) begin
      mem_q[addr_q] <= byte_in;
    end
  end

  // ==================================================================
  // Protocol state machine, updates on the falling link clock
  // Open-drain: oe_q high pulls SDA low, the line value is always 0.
  always_ff @(negedge link.scl or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= T_IDLE;
      cnt_q <= 3'h0;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      rw_q <= RW_WRITE;
      oe_q <= 1'b0;
      addr_q <= ADDR_RESET;
      hi_q <= '0;
      start_seen_q <= 1'b0;
      stop_seen_q <= 1'b0;
    end else begin
      start_seen_q <= start_tgl_q;
      stop_seen_q <= stop_tgl_q;
      if (cond_start) begin
        // Any START, even mid-byte, readies a fresh address phase
        state_q <= T_SLAVE;
        cnt_q <= 3'h0;
        oe_q <= 1'b0;
      end else if (cond_stop) begin
        state_q <= T_IDLE;
        oe_q <= 1'b0;
      end else begin
        rx_q <= byte_in;
        cnt_q <= cnt_q + 3'h1;
        case (state_q)
          T_SLAVE: begin
            if (cnt_q == BIT_LAST) begin
              if (addr_match) begin
                rw_q <= byte_in[0];
                oe_q <= 1'b1;
                state_q <= T_SLAVE_ACK;
              end else begin
                state_q <= T_IDLE;
              end
            end
          end
          T_SLAVE_ACK: begin
            cnt_q <= 3'h0;
            if (rw_q == RW_READ) begin
              oe_q <= ~mem_rd[7];
              tx_q <= {mem_rd[6:0], 1'b0};
              state_q <= T_RDATA;
            end else begin
              oe_q <= 1'b0;
              state_q <= T_MHI;
            end
          end
          T_MHI: begin
            if (cnt_q == BIT_LAST) begin
              hi_q <= byte_in[ADDR_W-BYTE_W-1:0];
              oe_q <= 1'b1;
              state_q <= T_MHI_ACK;
            end
          end
          T_MHI_ACK: begin
            cnt_q <= 3'h0;
            oe_q <= 1'b0;
            state_q <= T_MLO;
          end
          T_MLO: begin
            if (cnt_q == BIT_LAST) begin
              addr_q <= {hi_q, byte_in};
              oe_q <= 1'b1;
              state_q <= T_MLO_ACK;
            end
          end
          T_MLO_ACK: begin
            cnt_q <= 3'h0;
            oe_q <= 1'b0;
            state_q <= T_WDATA;
          end
          T_WDATA: begin
            if (cnt_q == BIT_LAST) begin
              addr_q <= addr_next;
              oe_q <= 1'b1;
              state_q <= T_WDATA_ACK;
            end
          end
          T_WDATA_ACK: begin
            cnt_q <= 3'h0;
            oe_q <= 1'b0;
            state_q <= T_WDATA;
          end
          T_RDATA: begin
            if (cnt_q == BIT_LAST) begin
              // Release for the controller's acknowledge
              oe_q <= 1'b0;
              addr_q <= addr_next;
              state_q <= T_RACK;
            end else begin
              oe_q <= ~tx_q[7];
              tx_q <= {tx_q[6:0], 1'b0};
            end
          end
          T_RACK: begin
            cnt_q <= 3'h0;
            if (!sda_pos_q) begin
              // Acked: next location is already in the latch
              oe_q <= ~mem_rd[7];
              tx_q <= {mem_rd[6:0], 1'b0};
              state_q <= T_RDATA;
            end else begin
              oe_q <= 1'b0;
              state_q <= T_IDLE;
            end
          end
          default: begin
            oe_q <= 1'b0;
            state_q <= T_IDLE;
          end
        endcase
      end
    end
  end

  // ==================================================================
  // Outputs
  always_ff @(negedge link.scl or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sda_o_q <= 1'b0;
    end else begin
      sda_o_q <= 1'b0;
    end
  end

  assign link.dev_sda_o = sda_o_q;
  assign link.dev_sda_oe = oe_q;
  assign current_addr_out = addr_q;

endmodule
`default_nettype wire

/* core/fri_pkg.sv */
// Shared constants for the two-wire memory read path
package fri_pkg;
  localparam int ADDR_W = 13;
  localparam int DSEL_W = 3;
  localparam int BYTE_W = 8;
  localparam int LEN_W = 8;
  // Arbitrary device type code, not tied to any real part
  localparam logic [3:0] DEV_TYPE = 4'h5;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 13'h0000;
  localparam logic [ADDR_W-1:0] ADDR_TOP = 13'h1FFF;
  localparam logic [ADDR_W-1:0] ADDR_WRAP = 13'h0000;
  // Ways to end a read
  localparam logic [1:0] END_NACK_STOP = 2'h0;
  localparam logic [1:0] END_NACK_START = 2'h1;
  localparam logic [1:0] END_STOP9 = 2'h2;
  localparam logic [1:0] END_START9 = 2'h3;
  // Link clock: least period, a quarter of it rounded up to clk cycles
  localparam int SCL_PERIOD_NS = 1000;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int QTR_CYC = (SCL_PERIOD_NS * 250 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

/* core/fri_link_if.sv */
// Two-wire link between bus controller and memory target
`timescale 1ns/1ps
`default_nettype none
interface fri_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;
  // Wired-AND with an implied pull-up
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface
`default_nettype wire

/* core/fri_controller.sv */
// Bus controller end of the two-wire link, makes the link clock
`timescale 1ns/1ps
`default_nettype none
module fri_controller
  import fri_pkg::*;
#(
  parameter int QTR_CYC_P = QTR_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  fri_link_if.host link,
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire logic cmd_read_in,
  input wire logic cmd_random_in,
  input wire logic [DSEL_W-1:0] cmd_dev_sel_in,
  input wire logic [ADDR_W-1:0] cmd_mem_addr_in,
  input wire logic [BYTE_W-1:0] cmd_wdata_in,
  input wire logic [LEN_W-1:0] cmd_len_in,
  input wire logic [1:0] cmd_end_in,
  output logic [BYTE_W-1:0] rd_data_out,
  output logic rd_valid_out,
  output logic done_out,
  output logic nack_out
);

  // ==================================================================
  // Declarations
  localparam int TW = $clog2(QTR_CYC_P + 1);
  typedef enum logic [2:0] {
    H_IDLE, H_START, H_TXB, H_TACK, H_RXB, H_MACK, H_NSTART, H_STOP
  } fri_hstate_e;
  typedef enum logic [2:0] {HB_SLAVE_W, HB_MHI, HB_MLO, HB_SLAVE_R, HB_WDATA} fri_hbyte_e;

  fri_hstate_e state_q;
  fri_hbyte_e byte_q;
  logic [TW-1:0] tcnt_q;
  logic [1:0] qtr_q;
  logic [2:0] cnt_q;
  logic [BYTE_W-1:0] sh_q;
  logic [LEN_W-1:0] rem_q;
  logic [DSEL_W-1:0] dsel_q;
  logic [ADDR_W-1:0] maddr_q;
  logic [BYTE_W-1:0] wdata_q;
  logic [1:0] end_q;
  logic read_q, ack_q, samp_q, scl_q, oe_q, sda_o_q, ready_q;
  logic sda_meta_q, sda_sync_q;
  logic tick, is_start, is_stop, tx_bit;

  assign tick = (state_q != H_IDLE) && (tcnt_q == TW'(QTR_CYC_P - 1));
  assign is_start = (state_q == H_START) || (state_q == H_NSTART);
  assign is_stop = state_q == H_STOP;
  assign tx_bit = (state_q == H_TXB) ? sh_q[7] : (state_q == H_MACK) ? ~ack_q : 1'b1;

  // ==================================================================
  // Quarter-period timer and SDA synchroniser
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tcnt_q <= '0;
    end else if (state_q == H_IDLE || tick) begin
      tcnt_q <= '0;
    end else begin
      tcnt_q <= tcnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sda_meta_q <= 1'b1;
      sda_sync_q <= 1'b1;
    end else begin
      sda_meta_q <= link.sda;
      sda_sync_q <= sda_meta_q;
    end
  end

  // ==================================================================
  // Sequencer: each symbol is four quarters, SCL low, rise, high, fall
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= H_IDLE;
      byte_q <= HB_SLAVE_W;
      qtr_q <= 2'h0;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      rem_q <= '0;
      dsel_q <= '0;
      maddr_q <= ADDR_RESET;
      wdata_q <= 8'h00;
      end_q <= END_NACK_STOP;
      read_q <= 1'b0;
      ack_q <= 1'b0;
      samp_q <= 1'b1;
      scl_q <= 1'b1;
      oe_q <= 1'b0;
      sda_o_q <= 1'b0;
      ready_q <= 1'b1;
      rd_data_out <= 8'h00;
      rd_valid_out <= 1'b0;
      done_out <= 1'b0;
      nack_out <= 1'b0;
    end else begin
      rd_valid_out <= 1'b0;
      done_out <= 1'b0;
      nack_out <= 1'b0;
      if (state_q == H_IDLE) begin
        if (cmd_valid_in && ready_q) begin
          ready_q <= 1'b0;
          read_q <= cmd_read_in;
          dsel_q <= cmd_dev_sel_in;
          maddr_q <= cmd_mem_addr_in;
          wdata_q <= cmd_wdata_in;
          rem_q <= cmd_len_in;
          end_q <= cmd_end_in;
          qtr_q <= 2'h0;
          state_q <= H_START;
          if (cmd_read_in && !cmd_random_in) begin
            byte_q <= HB_SLAVE_R;
            sh_q <= {DEV_TYPE, cmd_dev_sel_in, RW_READ};
          end else begin
            byte_q <= HB_SLAVE_W;
            sh_q <= {DEV_TYPE, cmd_dev_sel_in, RW_WRITE};
          end
        end
      end else if (tick) begin
        qtr_q <= qtr_q + 2'h1;
        case (qtr_q)
          2'h0: begin
            // START from an idle bus keeps SCL high; a low pulse there is a
            // stray clock that no frame owns
            scl_q <= is_start ? scl_q : 1'b0;
            oe_q <= is_stop ? 1'b1 : (is_start ? 1'b0 : ~tx_bit);
          end
          2'h1: begin
            scl_q <= 1'b1;
          end
          2'h2: begin
            if (is_start) begin
              oe_q <= 1'b1;
            end else if (is_stop) begin
              oe_q <= 1'b0;
            end else begin
              samp_q <= sda_sync_q;
            end
          end
          default: begin
            scl_q <= is_stop;
            cnt_q <= (state_q == H_TXB || state_q == H_RXB) ? cnt_q + 3'h1 : 3'h0;
            case (state_q)
              H_START: state_q <= H_TXB;
              H_NSTART: state_q <= H_STOP;
              H_TXB: begin
                sh_q <= {sh_q[6:0], 1'b0};
                if (cnt_q == BIT_LAST) state_q <= H_TACK;
              end
              H_TACK: begin
                if (samp_q) begin
                  nack_out <= 1'b1;
                  state_q <= H_STOP;
                end else begin
                  state_q <= H_TXB;
                  case (byte_q)
                    HB_SLAVE_W: begin
                      byte_q <= HB_MHI;
                      sh_q <= {{(2*BYTE_W-ADDR_W){1'b0}}, maddr_q[ADDR_W-1:BYTE_W]};
                    end
                    HB_MHI: begin
                      byte_q <= HB_MLO;
                      sh_q <= maddr_q[BYTE_W-1:0];
                    end
                    HB_MLO: begin
                      if (read_q) begin
                        byte_q <= HB_SLAVE_R;
                        sh_q <= {DEV_TYPE, dsel_q, RW_READ};
                        state_q <= H_START;
                      end else begin
                        byte_q <= HB_WDATA;
                        sh_q <= wdata_q;
                      end
                    end
                    HB_SLAVE_R: state_q <= H_RXB;
                    default: state_q <= H_STOP;
                  endcase
                end
              end
              H_RXB: begin
                sh_q <= {sh_q[6:0], samp_q};
                if (cnt_q == BIT_LAST) begin
                  rd_data_out <= {sh_q[6:0], samp_q};
                  rd_valid_out <= 1'b1;
                  rem_q <= rem_q - 1'b1;
                  ack_q <= rem_q > LEN_W'(1);
                  if (rem_q > LEN_W'(1) || end_q == END_NACK_STOP ||
                      end_q == END_NACK_START) begin
                    state_q <= H_MACK;
                  end else if (end_q == END_STOP9) begin
                    state_q <= H_STOP;
                  end else begin
                    state_q <= H_NSTART;
                  end
                end
              end
              H_MACK: begin
                if (ack_q) begin
                  state_q <= H_RXB;
                end else if (end_q == END_NACK_STOP) begin
                  state_q <= H_STOP;
                end else begin
                  state_q <= H_NSTART;
                end
              end
              H_STOP: begin
                done_out <= 1'b1;
                ready_q <= 1'b1;
                state_q <= H_IDLE;
              end
              default: state_q <= H_IDLE;
            endcase
          end
        endcase
      end
    end
  end

  assign link.scl = scl_q;
  assign link.host_sda_o = sda_o_q;
  assign link.host_sda_oe = oe_q;
  assign cmd_ready_out = ready_q;

endmodule
`default_nettype wire

/* testbench/fri_link_checker.sv */
// Link-level assertions for the two-wire read path
`timescale 1ns/1ps
`default_nettype none
module fri_link_checker (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe
);
  logic scl_q, sda_q, idle_q, rw_q, go_q, hi2, rise, start_c, stop_c;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  assign hi2 = scl & scl_q;
  assign rise = scl & ~scl_q;
  assign start_c = hi2 & sda_q & ~sda;
  assign stop_c = hi2 & ~sda_q & sda;
  // ==========================================
  // Frame tracking
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // Bit 9 of each group is the acknowledge slot
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      idle_q <= 1'b1;
      go_q <= 1'b0;
    end else if (start_c || stop_c) begin
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      idle_q <= stop_c;
      go_q <= 1'b0;
    end else if (rise) begin
      if (bit_q == 4'h9) begin
        bit_q <= 4'h1;
        byte_q <= (byte_q == 2'h2) ? byte_q : byte_q + 2'h1;
      end else begin
        bit_q <= bit_q + 4'h1;
      end
      if (bit_q == 4'h8) begin
        go_q <= ~sda;
      end
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rw_q <= 1'b0;
    end else if (rise && byte_q == 2'h0 && bit_q == 4'h7) begin
      rw_q <= sda;
    end
  end
  // ==========================================
  // Assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_dev_hold_high: assert property (hi2 |-> $stable(dev_sda_oe))
    else $error("target changed SDA while SCL high");
  a_start_by_host: assert property (start_c |-> host_sda_oe && !dev_sda_oe)
    else $error("START not made by the controller alone");
  a_nack_dev_off: assert property (rw_q && byte_q != 2'h0 && !go_q && !idle_q |-> !dev_sda_oe)
    else $error("target drove SDA after the read was refused");
  a_idle_dev_off: assert property (idle_q |-> !dev_sda_oe)
    else $error("target drove SDA on an idle bus");
  a_idle_scl_high: assert property (idle_q |-> scl)
    else $error("SCL low on an idle bus");
  a_addr_dev_off: assert property (byte_q == 2'h0 && bit_q <= 4'h8 && hi2 && !idle_q
      |-> !dev_sda_oe)
    else $error("target drove SDA during an address bit");
  a_read_host_off: assert property (rw_q && go_q && byte_q != 2'h0 && bit_q >= 4'h1
      && bit_q <= 4'h8 && hi2 |-> !host_sda_oe)
    else $error("controller drove SDA during a read data bit");
  a_ack_slot_free: assert property (rw_q && byte_q != 2'h0 && bit_q == 4'h9 && hi2
      |-> !dev_sda_oe)
    else $error("target drove SDA in the controller acknowledge slot");
  c_start: cover property (start_c);
  c_read_ack: cover property (rw_q && byte_q != 2'h0 && bit_q == 4'h9 && hi2 && !sda);
  c_stop_ninth: cover property (stop_c && bit_q == 4'h9);
  c_start_ninth: cover property (start_c && bit_q == 4'h9);
endmodule
`default_nettype wire

/* testbench/test_fram_i2c_read_path.sv */
// Self-checking bench joining controller and target over the link
`timescale 1ns/1ps
`default_nettype none
module test_fram_i2c_read_path
  import fri_pkg::*;
;
  localparam int WAIT_MAX = 20000;
  logic clk_in, rst_n_in, cmd_valid, cmd_read, cmd_random, cmd_ready, rd_valid, done, nack;
  logic s_scl, s_sda;
  logic [DSEL_W-1:0] cmd_dev_sel, dsel;
  logic [ADDR_W-1:0] cmd_mem_addr, cur_addr;
  logic [BYTE_W-1:0] cmd_wdata, rd_data, s_sh;
  logic [LEN_W-1:0] cmd_len;
  logic [1:0] cmd_end;
  logic [BYTE_W-1:0] exp_q[$], wire_q[$], ew[$];
  logic [BYTE_W-1:0] wdat [7];
  int err_count, comparisons, nack_seen, s_bit, idx;
  fri_link_if fri_link_if_i ();
  fri_controller #(.QTR_CYC_P(4)) fri_controller_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .link(fri_link_if_i.host), .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready),
    .cmd_read_in(cmd_read), .cmd_random_in(cmd_random), .cmd_dev_sel_in(cmd_dev_sel),
    .cmd_mem_addr_in(cmd_mem_addr), .cmd_wdata_in(cmd_wdata), .cmd_len_in(cmd_len),
    .cmd_end_in(cmd_end), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
    .done_out(done), .nack_out(nack));
  fri_target fri_target_i (.link(fri_link_if_i.dev), .rst_n_in(rst_n_in),
    .device_select_pins_in(dsel), .current_addr_out(cur_addr));
  fri_link_checker fri_link_checker_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .scl(fri_link_if_i.scl), .sda(fri_link_if_i.sda),
    .host_sda_oe(fri_link_if_i.host_sda_oe), .dev_sda_oe(fri_link_if_i.dev_sda_oe));
  // ==========================================
  // Checking
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(negedge clk_in) begin
    if (rd_valid === 1'b1) begin
      chk("read queue", 16'h0001, 16'(exp_q.size() > 0));
      if (exp_q.size() > 0) chk("read byte", 16'(exp_q.pop_front()), 16'(rd_data));
    end
    if (nack === 1'b1) nack_seen++;
  end
  // Wire sniffer: groups of nine clocks after each START, MSB shifted first
  always @(negedge clk_in) begin
    if (s_scl && fri_link_if_i.scl && s_sda && !fri_link_if_i.sda) begin
      s_bit = 0;
    end else if (!s_scl && fri_link_if_i.scl) begin
      if (s_bit < 8) s_sh = {s_sh[6:0], fri_link_if_i.sda};
      s_bit = (s_bit == 8) ? 0 : s_bit + 1;
      if (s_bit == 8) wire_q.push_back(s_sh);
    end
    s_scl = fri_link_if_i.scl;
    s_sda = fri_link_if_i.sda;
  end
  task automatic run_cmd(input logic rd, input logic rnd, input logic [ADDR_W-1:0] a,
      input logic [BYTE_W-1:0] wd, input logic [LEN_W-1:0] n, input logic [1:0] e,
      input logic [DSEL_W-1:0] ds);
    int t;
    t = 0;
    while (cmd_ready !== 1'b1 && t < WAIT_MAX) begin
      @(negedge clk_in);
      t++;
    end
    @(posedge clk_in);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_random <= rnd;
    cmd_mem_addr <= a;
    cmd_wdata <= wd;
    cmd_len <= n;
    cmd_end <= e;
    cmd_dev_sel <= ds;
    @(posedge clk_in);
    cmd_valid <= 1'b0;
    t = 0;
    do begin
      @(negedge clk_in);
      t++;
    end while (done !== 1'b1 && t < WAIT_MAX);
    chk("command done", 16'h0001, 16'(t < WAIT_MAX));
    chk("ready after done", 16'h0001, 16'(cmd_ready));
  endtask
  // ==========================================
  // Stimulus
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial begin
    // About five times the expected length of all tests
    repeat (40000) @(posedge clk_in);
    err_count++;
    $display("[FAIL] watchdog expected finish seen hang");
    test_done();
  end
  initial begin
    rst_n_in = 1'b0;
    {cmd_valid, cmd_read, cmd_random, cmd_mem_addr, cmd_wdata, cmd_len, cmd_end} = '0;
    cmd_dev_sel = '0;
    s_scl = 1'b1;
    s_sda = 1'b1;
    s_bit = 0;
    void'($urandom(32'hedbf_84c7));
    dsel = 3'($urandom);
    for (int k = 0; k < 7; k++) wdat[k] = 8'($urandom);
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    // Seven single writes straddling the top address
    for (int k = 0; k < 7; k++) begin
      run_cmd(1'b0, 1'b0, 13'h1ffc + 13'(k), wdat[k], 8'h01, END_NACK_STOP, dsel);
    end
    chk("latch after writes", 16'h0003, 16'(cur_addr));
    $display("test write_setup done");
    wire_q.delete();
    for (int k = 0; k < 3; k++) exp_q.push_back(wdat[k]);
    run_cmd(1'b1, 1'b1, 13'h1ffc, 8'h00, 8'h03, END_NACK_STOP, dsel);
    chk("latch after selective read", 16'h1fff, 16'(cur_addr));
    ew = '{{DEV_TYPE, dsel, RW_WRITE}, 8'h1f, 8'hfc, {DEV_TYPE, dsel, RW_READ},
      wdat[0], wdat[1], wdat[2]};
    chk("wire byte count", 16'h0007, 16'(wire_q.size()));
    for (int k = 0; k < 7 && k < wire_q.size(); k++) begin
      chk("wire byte", 16'(ew[k]), 16'(wire_q[k]));
    end
    $display("test selective_read done");
    // Current reads with the three other endings: nack+START, STOP in 9th, START in 9th
    idx = 3;
    for (int m = 0; m < 3; m++) begin
      for (int j = 0; j < ((m == 0) ? 2 : 1); j++) exp_q.push_back(wdat[idx + j]);
      idx += (m == 0) ? 2 : 1;
      run_cmd(1'b1, 1'b0, 13'h0000, 8'h00, (m == 0) ? 8'h02 : 8'h01, 2'(m + 1), dsel);
      chk("latch after current read", 16'(idx - 4), 16'(cur_addr));
      chk("bytes left", 16'h0000, 16'(exp_q.size()));
    end
    $display("test current_reads done");
    nack_seen = 0;
    run_cmd(1'b1, 1'b0, 13'h0000, 8'h00, 8'h01, END_NACK_STOP,
      dsel ^ 3'($urandom_range(7, 1)));
    chk("address refused", 16'h0001, 16'(nack_seen));
    chk("latch kept", 16'h0003, 16'(cur_addr));
    $display("test wrong_select done");
    exp_q.push_back(wdat[2]);
    exp_q.push_back(wdat[3]);
    run_cmd(1'b1, 1'b1, 13'h1ffe, 8'h00, 8'h02, END_NACK_STOP, dsel);
    chk("latch after recovery", 16'h0000, 16'(cur_addr));
    chk("bytes left", 16'h0000, 16'(exp_q.size()));
    $display("test recovery done");
    test_done();
  end
endmodule
`default_nettype wire
